// ### design/crcb_top.sv
// Function
// - 16-bit crc, msb first, generator polynomial 0x1021
// - first byte starts from selected seed, all zeros or all ones
// - each byte is xored into accumulator upper byte, low byte kept
// - bit step with bit 15 set shifts left then xors polynomial
// - bit step with bit 15 clear only shifts left
// - exactly eight conditional shift steps per input byte
// - seed all ones plus byte 0x63 yields the reference value 0xbd35
// - bit reverse register reads back last written byte mirrored
`timescale 1ns/1ps
`include "crcb_regs.svh"

module crcb_top
	import crcb_pkg::*;
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_wdata_in,
	output logic [7:0] sfr_rdata_out,
	output logic sfr_rvalid_out,
	output logic crc_in_ready_out
);
	crcb_stream_if wr_s();
	crcb_stream_if rd_s();

	crcb_state_t state_reg;
	crcb_state_t state_next;
	crcb_word_t acc_reg;
	crcb_word_t acc_next;
	logic [2:0] step_reg;
	logic [2:0] step_next;
	logic sel_reg;
	logic sel_next;
	crcb_byte_t flip_reg;
	crcb_byte_t flip_next;
	crcb_byte_t flip_rev;
	logic pend_reg;
	logic pend_next;
	crcb_byte_t pend_addr_reg;
	crcb_byte_t pend_addr_next;
	crcb_byte_t rdata_reg;
	crcb_byte_t rdata_next;
	logic rvalid_reg;
	logic rvalid_next;
	logic init_wr;
	logic busy;
	logic res_addr;
	logic answer;

	// ****************************************************************
	// byte buffer
	// ****************************************************************
	// a byte write while both entries are held is dropped; software
	// watches the ready pin
	assign wr_s.valid = sfr_wr_in && (sfr_addr_in == `CRCB_ADDR_DATA);
	assign wr_s.data = sfr_wdata_in;
	assign rd_s.ready = (state_reg == CRCB_IDLE) && !init_wr;

	crcb_fifo2 u_fifo
	(
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.wr_if(wr_s.snk),
		.rd_if(rd_s.src)
	);

	// ****************************************************************
	// crc engine
	// ****************************************************************
	assign init_wr = sfr_wr_in && (sfr_addr_in == `CRCB_ADDR_CTRL)
		&& sfr_wdata_in[`CRCB_CTRL_INIT];

	// one bit step per cycle; a seed write abandons a byte in flight
	always_comb
	begin
		state_next = state_reg;
		acc_next = acc_reg;
		step_next = step_reg;
		if (init_wr)
		begin
			acc_next = sfr_wdata_in[`CRCB_CTRL_SEL] ? `CRCB_INIT_ONES
				: `CRCB_INIT_ZERO;
			state_next = CRCB_IDLE;
		end
		else
		begin
			unique case (state_reg)
				CRCB_IDLE:
				begin
					if (rd_s.valid)
					begin
						acc_next = acc_reg ^ {rd_s.data, 8'h00};
						step_next = 3'h0;
						state_next = CRCB_SHIFT;
					end
				end
				CRCB_SHIFT:
				begin
					if (acc_reg[15])
					begin
						acc_next = {acc_reg[14:0], 1'b0} ^ `CRCB_POLY;
					end
					else
					begin
						acc_next = {acc_reg[14:0], 1'b0};
					end
					step_next = step_reg + 3'h1;
					if (step_reg == `CRCB_STEP_LAST)
					begin
						state_next = CRCB_IDLE;
					end
				end
			endcase
		end
	end

	// engine registers
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			state_reg <= CRCB_IDLE;
			acc_reg <= `CRCB_ACC_RST;
			step_reg <= 3'h0;
		end
		else
		begin
			state_reg <= state_next;
			acc_reg <= acc_next;
			step_reg <= step_next;
		end
	end

	// ****************************************************************
	// register file
	// ****************************************************************
	// mirrored view of the stored byte
	for (genvar i = 0; i < 8; i++)
	begin : g_rev
		assign flip_rev[i] = flip_reg[7 - i];
	end

	assign busy = (state_reg == CRCB_SHIFT) || rd_s.valid;
	assign res_addr = (pend_addr_reg == `CRCB_ADDR_RES_LO)
		|| (pend_addr_reg == `CRCB_ADDR_RES_HI);
	// result reads wait for the engine; a steady byte stream delays them
	assign answer = pend_reg && (!res_addr || !busy);

	// one read in flight; a second read while one waits is ignored
	always_comb
	begin
		sel_next = sel_reg;
		flip_next = flip_reg;
		pend_next = pend_reg;
		pend_addr_next = pend_addr_reg;
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		if (sfr_wr_in && (sfr_addr_in == `CRCB_ADDR_CTRL))
		begin
			sel_next = sfr_wdata_in[`CRCB_CTRL_SEL];
		end
		if (sfr_wr_in && (sfr_addr_in == `CRCB_ADDR_FLIP))
		begin
			flip_next = sfr_wdata_in;
		end
		if (answer)
		begin
			pend_next = 1'b0;
			rvalid_next = 1'b1;
			unique case (pend_addr_reg)
				`CRCB_ADDR_CTRL: rdata_next = {5'h00, busy, 1'b0, sel_reg};
				`CRCB_ADDR_RES_LO: rdata_next = acc_reg[7:0];
				`CRCB_ADDR_RES_HI: rdata_next = acc_reg[15:8];
				`CRCB_ADDR_FLIP: rdata_next = flip_rev;
				default: rdata_next = 8'h00; // unmapped
			endcase
		end
		else if (sfr_rd_in && !pend_reg)
		begin
			pend_next = 1'b1;
			pend_addr_next = sfr_addr_in;
		end
	end

	// register file registers
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			sel_reg <= 1'b0;
			flip_reg <= `CRCB_FLIP_RST;
			pend_reg <= 1'b0;
			pend_addr_reg <= 8'h00;
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			sel_reg <= sel_next;
			flip_reg <= flip_next;
			pend_reg <= pend_next;
			pend_addr_reg <= pend_addr_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign sfr_rdata_out = rdata_reg;
	assign sfr_rvalid_out = rvalid_reg;
	assign crc_in_ready_out = wr_s.ready;

	// ****************************************************************
	// checks
	// ****************************************************************
	// reference byte update, used only by the checks
	function automatic crcb_word_t crc_byte_f(crcb_word_t a, crcb_byte_t b);
		crcb_word_t r;
		r = a ^ {b, 8'h00};
		for (int k = 0; k < 8; k++)
		begin
			r = r[15] ? ({r[14:0], 1'b0} ^ `CRCB_POLY) : {r[14:0], 1'b0};
		end
		return r;
	endfunction

	crcb_word_t chk_acc_reg;
	crcb_byte_t chk_byte_reg;
	logic chk_fresh_reg;
	logic chk_ref_reg;
	logic pop;
	assign pop = rd_s.valid && rd_s.ready;

	// capture of each byte and its starting accumulator
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			chk_acc_reg <= 16'h0000;
			chk_byte_reg <= 8'h00;
			chk_fresh_reg <= 1'b0;
			chk_ref_reg <= 1'b0;
		end
		else
		begin
			if (pop)
			begin
				chk_acc_reg <= acc_reg;
				chk_byte_reg <= rd_s.data;
				chk_ref_reg <= chk_fresh_reg && (acc_reg == `CRCB_INIT_ONES)
					&& (rd_s.data == `CRCB_REF_IN);
				chk_fresh_reg <= 1'b0;
			end
			if (init_wr)
			begin
				chk_fresh_reg <= sfr_wdata_in[`CRCB_CTRL_SEL];
				chk_ref_reg <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);

	AST_BYTE_RESULT: assert property (
		$fell(state_reg == CRCB_SHIFT) && !$past(init_wr)
		|-> acc_reg == crc_byte_f(chk_acc_reg, chk_byte_reg))
		else $error("byte update result wrong");
	AST_SEED: assert property (
		init_wr |=> acc_reg == ($past(sfr_wdata_in[`CRCB_CTRL_SEL])
			? `CRCB_INIT_ONES : `CRCB_INIT_ZERO) && state_reg == CRCB_IDLE)
		else $error("seed not loaded");
	AST_XOR_HIGH: assert property (
		pop |=> acc_reg[7:0] == $past(acc_reg[7:0])
			&& acc_reg[15:8] == ($past(acc_reg[15:8]) ^ $past(rd_s.data)))
		else $error("byte not xored into upper half");
	AST_POLY_STEP: assert property (
		state_reg == CRCB_SHIFT && acc_reg[15] && !init_wr
		|=> acc_reg == (($past(acc_reg) << 1) ^ `CRCB_POLY))
		else $error("polynomial step wrong");
	AST_PLAIN_STEP: assert property (
		state_reg == CRCB_SHIFT && !acc_reg[15] && !init_wr
		|=> acc_reg == ($past(acc_reg) << 1))
		else $error("plain shift step wrong");
	AST_EIGHT_STEPS: assert property (
		pop ##1 (!init_wr throughout (state_reg == CRCB_SHIFT)[*8])
		|=> state_reg == CRCB_IDLE)
		else $error("step count not eight");
	AST_REFERENCE: assert property (
		$fell(state_reg == CRCB_SHIFT) && chk_ref_reg && !$past(init_wr)
		|-> acc_reg == `CRCB_REF_OUT)
		else $error("reference value not reproduced");
	AST_FLIP_READ: assert property (
		answer && pend_addr_reg == `CRCB_ADDR_FLIP
		|=> sfr_rvalid_out
			&& sfr_rdata_out == crcb_byte_t'({<<{$past(flip_reg)}}))
		else $error("bit reverse read wrong");
	// the answer must carry the settled accumulator half, not just wait
	AST_RESULT_STABLE: assert property (
		answer && res_addr |-> state_reg == CRCB_IDLE && !rd_s.valid
		##1 sfr_rvalid_out && sfr_rdata_out ==
		(($past(pend_addr_reg) == `CRCB_ADDR_RES_LO) ? $past(acc_reg[7:0])
			: $past(acc_reg[15:8])))
		else $error("result served mid update");
	AST_READY_RETURNS: assert property (
		!crc_in_ready_out && !init_wr |-> ##[1:12] crc_in_ready_out)
		else $error("byte buffer stalled too long");

	COV_BYTE_DONE: cover property ($fell(state_reg == CRCB_SHIFT));
	COV_BUF_FULL: cover property (!crc_in_ready_out);
	COV_READ_WAITS: cover property (pend_reg && res_addr && busy);
	COV_REF_HIT: cover property ($fell(state_reg == CRCB_SHIFT)
		&& chk_ref_reg);

endmodule

// ### include/crcb_regs.svh
`ifndef CRCB_REGS_SVH
`define CRCB_REGS_SVH

// ****************************************************************
// register addresses on the special-function register port
// ****************************************************************
`define CRCB_ADDR_CTRL 8'h91
`define CRCB_ADDR_DATA 8'h92
`define CRCB_ADDR_RES_LO 8'h93
`define CRCB_ADDR_RES_HI 8'h94
`define CRCB_ADDR_FLIP 8'h95

// ****************************************************************
// control register fields
// ****************************************************************
`define CRCB_CTRL_SEL 0
`define CRCB_CTRL_INIT 1
`define CRCB_CTRL_BUSY 2

// ****************************************************************
// crc arithmetic, reset values and counts
// ****************************************************************
`define CRCB_POLY 16'h1021
`define CRCB_INIT_ZERO 16'h0000
`define CRCB_INIT_ONES 16'hffff
`define CRCB_ACC_RST 16'h0000
`define CRCB_FLIP_RST 8'h00
`define CRCB_STEP_LAST 3'h7
`define CRCB_REF_IN 8'h63
`define CRCB_REF_OUT 16'hbd35

`endif

// ### include/crcb_pkg.sv
package crcb_pkg;

	typedef logic [7:0] crcb_byte_t;
	typedef logic [15:0] crcb_word_t;

	// engine states
	typedef enum logic [0:0]
	{
		CRCB_IDLE = 1'b0,
		CRCB_SHIFT = 1'b1
	} crcb_state_t;

endpackage

// ### include/crcb_stream_if.sv
`timescale 1ns/1ps

// byte stream with valid and ready
interface crcb_stream_if;
	logic valid;
	logic ready;
	logic [7:0] data;

	modport src
	(
		output valid,
		output data,
		input ready
	);

	modport snk
	(
		input valid,
		input data,
		output ready
	);
endinterface

// ### design/crcb_fifo2.sv
`timescale 1ns/1ps

module crcb_fifo2
	import crcb_pkg::*;
(
	input wire logic clk_in,
	input wire logic nrst_in,
	crcb_stream_if.snk wr_if,
	crcb_stream_if.src rd_if
);
	localparam int unsigned DEPTH = 2;

	crcb_byte_t mem_reg [DEPTH];
	crcb_byte_t mem_next [DEPTH];
	logic wptr_reg;
	logic wptr_next;
	logic rptr_reg;
	logic rptr_next;
	logic [1:0] count_reg;
	logic [1:0] count_next;
	logic valid_reg;
	logic ready_reg;
	logic push;
	logic pop;

	// ****************************************************************
	// handshakes
	// ****************************************************************
	assign push = wr_if.valid && ready_reg;
	assign pop = valid_reg && rd_if.ready;
	assign wr_if.ready = ready_reg;
	assign rd_if.valid = valid_reg;
	assign rd_if.data = mem_reg[rptr_reg];

	// ****************************************************************
	// next state
	// ****************************************************************
	// flags come from registers so the block pins see flop outputs
	always_comb
	begin
		mem_next = mem_reg;
		wptr_next = wptr_reg;
		rptr_next = rptr_reg;
		count_next = count_reg;
		if (push)
		begin
			mem_next[wptr_reg] = wr_if.data;
			wptr_next = ~wptr_reg;
		end
		if (pop)
		begin
			rptr_next = ~rptr_reg;
		end
		if (push && !pop)
		begin
			count_next = count_reg + 2'h1;
		end
		else if (pop && !push)
		begin
			count_next = count_reg - 2'h1;
		end
	end

	// registers only
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			mem_reg <= '{default: 8'h00};
			wptr_reg <= 1'b0;
			rptr_reg <= 1'b0;
			count_reg <= 2'h0;
			valid_reg <= 1'b0;
			ready_reg <= 1'b0;
		end
		else
		begin
			mem_reg <= mem_next;
			wptr_reg <= wptr_next;
			rptr_reg <= rptr_next;
			count_reg <= count_next;
			valid_reg <= (count_next != 2'h0);
			ready_reg <= (count_next != 2'h2);
		end
	end

endmodule

// ### bench/crcb_top_tb.sv
`timescale 1ns/1ps
`include "crcb_regs.svh"

module crcb_top_tb
	import crcb_pkg::*;
;
	// ********
	// signals
	// ********
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [7:0] sfr_addr_in = 8'h00;
	logic sfr_wr_in = 1'b0;
	logic sfr_rd_in = 1'b0;
	logic [7:0] sfr_wdata_in = 8'h00;
	logic [7:0] sfr_rdata_out;
	logic sfr_rvalid_out;
	logic crc_in_ready_out;
	int n_errors = 0;
	int n_tests = 0;
	int n_stalls = 0;
	crcb_byte_t exp_q[$];
	string name_q[$];

	// 250 mhz clock
	always #2 clk_in = ~clk_in;

	crcb_top crcb_top_i
	(
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.sfr_addr_in(sfr_addr_in),
		.sfr_wr_in(sfr_wr_in),
		.sfr_rd_in(sfr_rd_in),
		.sfr_wdata_in(sfr_wdata_in),
		.sfr_rdata_out(sfr_rdata_out),
		.sfr_rvalid_out(sfr_rvalid_out),
		.crc_in_ready_out(crc_in_ready_out)
	);

	// ********
	// checking
	// ********
	// each answer consumes the oldest note; pre-edge values are sampled
	always @(posedge clk_in)
	begin
		if (nrst_in === 1'b1 && sfr_rvalid_out === 1'b1)
		begin
			n_tests++;
			if (exp_q.size() == 0)
			begin
				n_errors++;
				$display("[ERR] stray answer expected none seen %h",
					sfr_rdata_out);
			end
			else
			begin
				if (sfr_rdata_out !== exp_q[0])
				begin
					n_errors++;
					$display("[ERR] %s expected %h seen %h", name_q[0],
						exp_q[0], sfr_rdata_out);
				end
				void'(exp_q.pop_front());
				void'(name_q.pop_front());
			end
		end
	end

	task automatic wrap_up();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic give_up(input string what);
		n_errors++;
		$display("[ERR] %s expected done seen timeout", what);
		wrap_up();
	endtask

	// ********
	// bus tasks
	// ********
	// a data write is held until the buffer shows ready at the edge
	task automatic wr(input logic [7:0] a, input crcb_byte_t d);
		int i;
		@(posedge clk_in);
		sfr_addr_in <= a;
		sfr_wdata_in <= d;
		sfr_wr_in <= 1'b1;
		for (i = 0; i < 40; i++)
		begin
			@(posedge clk_in);
			if (a != `CRCB_ADDR_DATA || crc_in_ready_out === 1'b1)
				break;
		end
		if (i == 40)
			give_up("data write");
		// a data write that had to wait saw the buffer full
		if (i > 0 && a == `CRCB_ADDR_DATA)
			n_stalls++;
		sfr_wr_in <= 1'b0;
	endtask

	// one read at a time: wait for its answer before returning
	task automatic rd(input logic [7:0] a, input crcb_byte_t e,
		input string nm);
		int i;
		@(posedge clk_in);
		sfr_addr_in <= a;
		sfr_rd_in <= 1'b1;
		exp_q.push_back(e);
		name_q.push_back(nm);
		@(posedge clk_in);
		sfr_rd_in <= 1'b0;
		for (i = 0; i < 200 && exp_q.size() != 0; i++)
			@(posedge clk_in);
		if (exp_q.size() != 0)
			give_up(nm);
	endtask

	task automatic rd_res(input crcb_word_t e, input string nm);
		rd(`CRCB_ADDR_RES_LO, e[7:0], {nm, " lo"});
		rd(`CRCB_ADDR_RES_HI, e[15:8], {nm, " hi"});
	endtask

	// bench model of one byte update, msb first
	function automatic crcb_word_t crc_step(crcb_word_t acc, crcb_byte_t b);
		acc = acc ^ {b, 8'h00};
		for (int k = 0; k < 8; k++)
			acc = acc[15] ? ({acc[14:0], 1'b0} ^ 16'h1021) : {acc[14:0], 1'b0};
		return acc;
	endfunction

	// seed, feed bytes back to back, then read both result halves
	task automatic run_msg(input logic sel, input crcb_byte_t m[$],
		input crcb_word_t e, input string nm);
		wr(`CRCB_ADDR_CTRL, {6'h00, 1'b1, sel});
		foreach (m[j])
			wr(`CRCB_ADDR_DATA, m[j]);
		rd_res(e, nm);
		$display("test %s done", nm);
	endtask

	task automatic do_reset();
		int i;
		@(posedge clk_in);
		nrst_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		nrst_in <= 1'b1;
		for (i = 0; i < 20 && crc_in_ready_out !== 1'b1; i++)
			@(posedge clk_in);
		if (i == 20)
			give_up("ready after reset");
		rd(`CRCB_ADDR_FLIP, 8'h00, "flip reset");
		rd_res(16'h0000, "acc reset");
		rd(8'h90, 8'h00, "unmapped");
		$display("test reset done");
	endtask

	// ********
	// sequence
	// ********
	initial
	begin
		crcb_byte_t b;
		crcb_byte_t c;
		crcb_byte_t m[$];
		crcb_word_t e;
		void'($urandom(5586));
		do_reset();
		wr(`CRCB_ADDR_FLIP, 8'hc0);
		rd(`CRCB_ADDR_FLIP, 8'h03, "flip c0");
		wr(`CRCB_ADDR_FLIP, 8'h05);
		rd(`CRCB_ADDR_FLIP, 8'ha0, "flip 05");
		repeat (6)
		begin
			b = 8'($urandom);
			c = 8'($urandom);
			wr(`CRCB_ADDR_FLIP, b);
			wr(`CRCB_ADDR_FLIP, c);
			rd(`CRCB_ADDR_FLIP, crcb_byte_t'({<<{c}}), "flip rand");
		end
		$display("test flip done");
		wr(`CRCB_ADDR_CTRL, 8'h02);
		rd_res(16'h0000, "seed zero");
		wr(`CRCB_ADDR_CTRL, 8'h03);
		rd_res(16'hffff, "seed ones");
		run_msg(1'b1, '{8'h63}, 16'hbd35, "ref 63");
		// control reads are served at once and show the engine busy
		wr(`CRCB_ADDR_CTRL, 8'h03);
		wr(`CRCB_ADDR_DATA, 8'h63);
		rd(`CRCB_ADDR_CTRL, 8'h05, "ctrl busy");
		rd_res(16'hbd35, "busy ref");
		rd(`CRCB_ADDR_CTRL, 8'h01, "ctrl idle");
		rd(`CRCB_ADDR_DATA, 8'h00, "data reads zero");
		$display("test ctrl done");
		run_msg(1'b1, '{8'haa, 8'hbb, 8'hcc}, 16'h6cf6, "ref 3");
		run_msg(1'b1, '{8'h00, 8'h00, 8'haa, 8'hbb, 8'hcc}, 16'hb166,
			"ref 5");
		// five bytes back to back must have filled the two-entry buffer
		n_tests++;
		if (n_stalls == 0)
		begin
			n_errors++;
			$display("[ERR] buffer stall expected >0 seen %0d", n_stalls);
		end
		run_msg(1'b0, '{8'h00}, 16'h0000, "zero byte");
		// random messages exercise both branches and a full buffer
		repeat (4)
		begin
			m.delete();
			e = 16'h0000;
			repeat (1 + $urandom % 6)
			begin
				b = 8'($urandom);
				m.push_back(b);
				e = crc_step(e, b);
			end
			run_msg(1'b0, m, e, "rand zero");
		end
		// result registers are read only; a write must not disturb them
		wr(`CRCB_ADDR_RES_LO, 8'h5a);
		wr(`CRCB_ADDR_RES_HI, 8'ha5);
		rd_res(e, "ro write");
		$display("test ro done");
		do_reset();
		wrap_up();
	end
endmodule
